// ---- include/adsi_regs.svh ----
// Contract
// - Copy each header's version and rate code.
// - Version plus code select sampling rate.
// - Version bit reports first or second standard.
// - Ancillary bytes presented one at a time.
// - Ancillary flag follows buffer non-empty only.
// - Ancillary flag can raise decoder interrupt.
// - Five interrupt sources, each with mask.
// - Set mask blocks source; bits 4..0.
// - Interrupt needs decoder and global enable.
// - Status read clears four flags, not ancillary.
// - Control at AAh; enable, boost, CRC, masks.
// - Bass boost applied while bit 6 set.
// - Bit 5 set plays bad-CRC frames.
// - Control resets to 0x3F.
// - Version bit set for first version.
// - Status read-only at C8h, resets 0x01.
// - Layer error on unsupported header layer.
// - Request flag when decoder needs input.
`ifndef ADSI_REGS_SVH
`define ADSI_REGS_SVH
// ==========================================================
// Register addresses and layouts.
`define ADSI_CONTROL_ADDR   8'hAA
`define ADSI_STATUS_ADDR    8'hC8
`define ADSI_AUX_ADDR       8'hAD
`define ADSI_CONTROL_RESET  8'h3F
`define ADSI_STATUS_RESET   8'h01
`define ADSI_CTL_ENABLE     7
`define ADSI_CTL_BOOST      6
`define ADSI_CTL_PLAYBAD    5
`define ADSI_ST_AUX         7
`define ADSI_ST_REQ         6
`define ADSI_ST_LAYER       5
`define ADSI_ST_SYNC        4
`define ADSI_ST_CRC         3
`endif

// ---- include/adsi_pkg.sv ----
package adsi_pkg;
  // ========================================================
  // Sampling rate decode of version bit and rate code.
  typedef enum logic [2:0] {
    ADSI_FS_22K05, ADSI_FS_24K, ADSI_FS_16K, ADSI_FS_44K1,
    ADSI_FS_48K, ADSI_FS_32K, ADSI_FS_RESERVED
  } adsi_rate_t;
endpackage : adsi_pkg

// ---- rtl/adsi_status_irq.sv ----
`timescale 1ns/1ns
`include "adsi_regs.svh"
module adsi_status_irq
  import adsi_pkg::*;
#(
  parameter int AUX_DEPTH = 4
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       hdr_valid,
  input  wire logic       hdr_version,
  input  wire logic [1:0] hdr_rate_code,
  input  wire logic       aux_valid,
  input  wire logic [7:0] aux_byte,
  output logic            aux_ready,
  input  wire logic       crc_err_evt,
  input  wire logic       sync_err_evt,
  input  wire logic       layer_err_evt,
  input  wire logic       data_req_evt,
  input  wire logic       decoder_irq_enable,
  input  wire logic       global_irq_enable,
  output logic            decoder_irq,
  output logic            decoder_enable_bit,
  output logic            low_boost_bit,
  output logic            play_bad_frames_bit,
  output adsi_rate_t      sample_rate
);
  // Depth must be a power of two of at least two; the pointers wrap by overflow.
  localparam int PW = $clog2(AUX_DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(AUX_DEPTH);

  // ========================================================
  // State record.
  typedef struct packed {
    logic [7:0]                 ctl;
    logic [6:0]                 sta;
    logic [AUX_DEPTH-1:0][7:0]  buf_q;
    logic [PW-1:0]              rptr;
    logic [PW-1:0]              wptr;
    logic [PW:0]                cnt;
    logic [7:0]                 rdata;
    logic                       irq;
    logic                       ready;
    adsi_rate_t                 rate;
  } adsi_state_t;

  adsi_state_t st_reg;
  adsi_state_t st_next;

  function automatic adsi_rate_t adsi_decode(input logic v, input logic [1:0] c);
    adsi_rate_t r;
    r = ADSI_FS_RESERVED;
    case ({v, c})
      3'b000:  r = ADSI_FS_22K05;
      3'b001:  r = ADSI_FS_24K;
      3'b010:  r = ADSI_FS_16K;
      3'b100:  r = ADSI_FS_44K1;
      3'b101:  r = ADSI_FS_48K;
      3'b110:  r = ADSI_FS_32K;
      default: r = ADSI_FS_RESERVED;
    endcase
    return r;
  endfunction : adsi_decode

  // ========================================================
  // Bus decode and event collection.
  logic             rd_sta;
  logic             rd_aux;
  logic             wr_ctl;
  logic             aux_push;
  logic             aux_pop;
  logic [PW:0]      cnt_next;
  logic [7:0]       ctl_next;
  logic [3:0]       evt_vec;
  logic [3:0]       flag_cur;
  logic [3:0]       flag_nxt;
  logic [4:0]       src_vec;
  logic [4:0]       src_live;

  assign rd_sta   = sfr_rd && (sfr_addr == `ADSI_STATUS_ADDR);
  assign rd_aux   = sfr_rd && (sfr_addr == `ADSI_AUX_ADDR);
  assign wr_ctl   = sfr_wr && (sfr_addr == `ADSI_CONTROL_ADDR);
  // A full buffer refuses the byte; the producer keeps it until ready returns.
  assign aux_push = aux_valid && st_reg.ready;
  assign aux_pop  = rd_aux && (st_reg.cnt != '0);
  assign cnt_next = st_reg.cnt + (PW+1)'(aux_push) - (PW+1)'(aux_pop);
  assign ctl_next = wr_ctl ? sfr_wdata : st_reg.ctl;
  // Bit order follows the status register, lowest flag first.
  assign evt_vec  = {data_req_evt, layer_err_evt, sync_err_evt, crc_err_evt};
  assign flag_cur = st_reg.sta[6:3];
  assign src_vec  = {(cnt_next != '0), flag_nxt};

  // ========================================================
  // Read multiplexer; unmapped addresses read as zero.
  logic [7:0] full_sta;
  logic [7:0] rd_mux;

  assign full_sta = {(st_reg.cnt != '0), st_reg.sta};

  always_comb begin
    case (sfr_addr)
      `ADSI_CONTROL_ADDR: rd_mux = st_reg.ctl;
      `ADSI_STATUS_ADDR:  rd_mux = full_sta;
      `ADSI_AUX_ADDR:     rd_mux = st_reg.buf_q[st_reg.rptr];
      default:            rd_mux = 8'h00;
    endcase
  end

  // ========================================================
  // Sticky flags; a status read clears them unless an event lands with it.
  for (genvar g = 0; g < 4; g++) begin : g_flag
    adsi_flag_cell i_flag (
      .cur (flag_cur[g]),
      .clr (rd_sta),
      .set (evt_vec[g]),
      .nxt (flag_nxt[g])
    );
  end

  // ========================================================
  // Source gating; a set mask bit keeps its source away from the request.
  for (genvar g = 0; g < 5; g++) begin : g_gate
    adsi_src_gate i_gate (
      .flag (src_vec[g]),
      .mask (ctl_next[g]),
      .live (src_live[g])
    );
  end

  // ========================================================
  // Next-state logic.
  always_comb begin
    st_next = st_reg;
    // Reads return the value before any clearing takes effect.
    if (sfr_rd) begin
      st_next.rdata = rd_mux;
    end
    st_next.ctl      = ctl_next;
    st_next.sta[6:3] = flag_nxt;
    // The rate is decoded once per header, so the output never glitches.
    if (hdr_valid) begin
      st_next.sta[2:0] = {hdr_rate_code, hdr_version};
      st_next.rate     = adsi_decode(hdr_version, hdr_rate_code);
    end
    if (aux_push) begin
      st_next.buf_q[st_reg.wptr] = aux_byte;
      st_next.wptr = st_reg.wptr + PW'(1);
    end
    if (aux_pop) begin
      st_next.rptr = st_reg.rptr + PW'(1);
    end
    st_next.cnt   = cnt_next;
    // Ready is registered, so a slot freed by a read is offered one cycle later.
    st_next.ready = (cnt_next != FULL_CNT);
    st_next.irq   = (|src_live)
                    && decoder_irq_enable && global_irq_enable;
  end

  // ========================================================
  // State register; the clock enable freezes everything except the synchronous reset.
  always_ff @(posedge clk) begin
    // Reset does not wait for the enable, so the block always starts clean.
    if (srst) begin
      st_reg       <= '0;
      st_reg.ctl   <= `ADSI_CONTROL_RESET;
      st_reg.sta   <= 7'(`ADSI_STATUS_RESET);
      st_reg.rate  <= ADSI_FS_44K1;
      st_reg.ready <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata           = st_reg.rdata;
  assign decoder_irq         = st_reg.irq;
  assign decoder_enable_bit  = st_reg.ctl[`ADSI_CTL_ENABLE];
  assign low_boost_bit       = st_reg.ctl[`ADSI_CTL_BOOST];
  assign play_bad_frames_bit = st_reg.ctl[`ADSI_CTL_PLAYBAD];
  assign sample_rate         = st_reg.rate;
  assign aux_ready           = st_reg.ready;
endmodule : adsi_status_irq

// ========================================================
// Next value of sticky flags: cleared by a read, set by their events.
module adsi_flag_cell
  import adsi_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic [W-1:0] cur,
  input  wire logic         clr,
  input  wire logic [W-1:0] set,
  output logic      [W-1:0] nxt
);
  // The set term is ORed last, so an event in the read cycle is kept.
  always_comb begin
    nxt = (cur & ~{W{clr}}) | set;
  end
endmodule : adsi_flag_cell

// ========================================================
// Mask gate of interrupt sources.
module adsi_src_gate
  import adsi_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic [W-1:0] flag,
  input  wire logic [W-1:0] mask,
  output logic      [W-1:0] live
);
  // A set mask blocks the source; a clear one lets it through.
  always_comb begin
    live = flag & ~mask;
  end
endmodule : adsi_src_gate

// ---- verif/adsi_status_irq_chk.sv ----
`timescale 1ns/1ns
// ==========
// Port checks of the status and interrupt block.
module adsi_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       sfr_rd,
  input wire logic       sfr_wr,
  input wire logic       crc_err_evt,
  input wire logic       aux_ready,
  input wire logic       decoder_irq,
  input wire logic       decoder_irq_enable,
  input wire logic       global_irq_enable,
  input wire logic       low_boost_bit,
  input wire logic       play_bad_frames_bit,
  input wire logic       decoder_enable_bit,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire logic st = ce && sfr_rd && sfr_addr == 8'hC8;
  AST_IRQ_EN: assert property (ce && !(decoder_irq_enable && global_irq_enable) |=> !decoder_irq)
    else $error("irq without enables");
  AST_CTL_WR: assert property (ce && sfr_wr && sfr_addr == 8'hAA
    |=> low_boost_bit == $past(sfr_wdata[6]))
    else $error("boost bit not written");
  AST_RST: assert property ($fell(srst) |-> !decoder_enable_bit && !low_boost_bit && play_bad_frames_bit)
    else $error("control reset wrong");
  AST_SET: assert property (ce && crc_err_evt ##1 st |=> sfr_rdata[3])
    else $error("crc flag lost");
  AST_CLR: assert property (st && !crc_err_evt ##1 st |=> !sfr_rdata[3])
    else $error("crc flag not cleared");
  AST_AUX: assert property (st && !aux_ready |=> sfr_rdata[7])
    else $error("aux flag low while full");
  AST_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  AST_UNMAP: assert property (ce && sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (st && !aux_ready);
  cover property ($rose(decoder_irq));
  cover property (crc_err_evt ##1 st);
endmodule : adsi_chk
bind adsi_status_irq adsi_chk i_chk (.clk, .srst, .ce, .sfr_rd, .sfr_wr, .crc_err_evt, .aux_ready,
  .decoder_irq, .decoder_irq_enable, .global_irq_enable, .low_boost_bit, .play_bad_frames_bit,
  .decoder_enable_bit, .sfr_addr, .sfr_wdata, .sfr_rdata);

// ---- verif/adsi_cpu_model.sv ----
`timescale 1ns/1ns
// ==========
// Core model; the idle address is inverted so stale decoding is exposed.
module adsi_cpu_model (
  input wire logic        clk,
  output logic            sfr_rd, sfr_wr,
  output logic      [7:0] sfr_addr, sfr_wdata
);
  initial {sfr_rd, sfr_wr, sfr_addr, sfr_wdata} = '0;
  task automatic acc(logic w, logic [7:0] a, d, int n);
    @(posedge clk) {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {w, !w, a, d};
    repeat (n) @(posedge clk);
    {sfr_wr, sfr_rd, sfr_addr} <= {2'b00, ~a};
    @(posedge clk);
  endtask : acc
endmodule : adsi_cpu_model

// ---- verif/adsi_status_irq_tb.sv ----
`timescale 1ns/1ns
// ==========
// Self-checking bench; the core model drives the register strobes.
module adsi_status_irq_tb import adsi_pkg::*; ;
  logic clk = 0, srst = 1, ce = 1, hdr_valid = 0, hdr_version = 0, aux_valid = 0;
  logic decoder_irq_enable = 0, global_irq_enable = 0, sfr_rd, sfr_wr, aux_ready, decoder_irq;
  logic decoder_enable_bit, low_boost_bit, play_bad_frames_bit;
  logic [1:0] hdr_rate_code = 0;
  logic [3:0] ev = 0;
  logic [7:0] aux_byte = 0, sfr_addr, sfr_wdata, sfr_rdata, c, st, q[$];
  logic [31:0] seed = 32'hbfb3;
  adsi_rate_t sample_rate;
  int fail_count = 0, compares = 0;
  adsi_status_irq #(.AUX_DEPTH(4)) i_dut (.clk, .srst, .ce, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .hdr_valid, .hdr_version, .hdr_rate_code, .aux_valid, .aux_byte,
    .aux_ready, .crc_err_evt(ev[0]), .sync_err_evt(ev[1]), .layer_err_evt(ev[2]),
    .data_req_evt(ev[3]), .decoder_irq_enable, .global_irq_enable, .decoder_irq,
    .decoder_enable_bit, .low_boost_bit, .play_bad_frames_bit, .sample_rate);
  adsi_cpu_model i_cpu (.clk, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata);
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  function automatic logic [7:0] rate(int i);
    return (i[1:0] == 2'h3) ? 8'(ADSI_FS_RESERVED) : 8'(i[2] * 3 + i[1:0]);
  endfunction : rate
  task automatic chk(string n, logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(logic [7:0] a, e, int n = 1);
    i_cpu.acc(0, a, 0, n);
    chk($sformatf("reg %h", a), sfr_rdata, e);
  endtask : rd
  task automatic pulse(logic [3:0] e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= 0;
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 0;
    rd(8'hAA, 8'h3F);
    rd(8'hC8, 8'h01);
    rd(8'h00, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) {hdr_valid, hdr_version, hdr_rate_code} <= {1'b1, 3'(i)};
      @(posedge clk) hdr_valid <= 0;
      rd(8'hC8, {5'h0, 2'(i), i[2]});
      chk("rate", 8'(sample_rate), rate(i));
    end
    $display("header test done");
    repeat (4) begin
      c = xs();
      i_cpu.acc(1, 8'hAA, c, 1);
      rd(8'hAA, c);
      chk("ctl", {decoder_enable_bit, low_boost_bit, play_bad_frames_bit}, c[7:5]);
    end
    $display("control test done");
    {decoder_irq_enable, global_irq_enable} <= 2'b11;
    i_cpu.acc(1, 8'hAA, 8'h00, 1);
    for (int i = 0; i < 4; i++) begin
      pulse(4'(1 << i));
      chk("irq", 8'(decoder_irq), 8'h01);
      rd(8'hC8, 8'h07 | 8'(8 << i));
      rd(8'hC8, 8'h07, 2);
      chk("irq", 8'(decoder_irq), 8'h00);
    end
    fork
      i_cpu.acc(0, 8'hC8, 0, 2);
      pulse(4'h1);
    join
    chk("race", sfr_rdata, 8'h0F);
    i_cpu.acc(1, 8'hAA, 8'h1F, 1);
    pulse(4'hF);
    chk("irq", 8'(decoder_irq), 8'h00);
    i_cpu.acc(1, 8'hAA, 8'h00, 1);
    global_irq_enable <= 0;
    repeat (2) @(negedge clk);
    chk("irq", 8'(decoder_irq), 8'h00);
    @(posedge clk) global_irq_enable <= 1;
    repeat (2) @(negedge clk);
    chk("irq", 8'(decoder_irq), 8'h01);
    i_cpu.acc(0, 8'hC8, 0, 1);
    st = sfr_rdata;
    chk("copy", st, 8'h7F);
    $display("interrupt test done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) {aux_valid, aux_byte} <= {1'b1, xs()};
      @(negedge clk) if (aux_ready) q.push_back(aux_byte);
      @(posedge clk) aux_valid <= 0;
    end
    chk("full", 8'(aux_ready), 8'h00);
    rd(8'hC8, 8'h87, 2);
    chk("irq", 8'(decoder_irq), 8'h01);
    while (q.size() > 0) rd(8'hAD, q.pop_front());
    rd(8'hC8, 8'h07);
    chk("irq", 8'(decoder_irq), 8'h00);
    $display("aux buffer test done");
    @(posedge clk) ce <= 0;
    pulse(4'h1);
    @(posedge clk) ce <= 1;
    rd(8'hC8, 8'h07);
    $display("clock enable test done");
    srst <= 1;
    @(posedge clk) srst <= 0;
    rd(8'hAA, 8'h3F);
    rd(8'hC8, 8'h01);
    $display("second reset test done");
    finish_test();
  end
endmodule : adsi_status_irq_tb
